// ---- rtl/mcd_defines.svh ----
/*
  Constants of the multi-channel mover: register offsets, channel word
  indices, configuration field positions and bus encodings.
  Assumes it is included by bare name and holds definitions only.
*/
`ifndef MCD_DEFINES_SVH
`define MCD_DEFINES_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define MCD_NCH 8
`define MCD_NREQ 64
`define MCD_CNT_W 17
`define MCD_CNT_MAX 17'h10000
`define MCD_CFG_W 19

// ****************************************************************
// global registers, byte offsets
// ****************************************************************
`define MCD_REG_STATUS 12'h000
`define MCD_REG_MASK 12'h004
`define MCD_REG_TRIGEN 12'h008
`define MCD_REG_SWREQ 12'h00C
`define MCD_REG_ACTIVE 12'h010
// channel windows: 0x100 + 0x20 * channel
`define MCD_CH_PAGE 4'h1

// ****************************************************************
// channel word indices inside a window
// ****************************************************************
`define MCD_CH_CFG 3'h0
`define MCD_CH_SRC 3'h1
`define MCD_CH_DST 3'h2
`define MCD_CH_CNT 3'h3
`define MCD_CH_BLK 3'h4
`define MCD_CH_REMAIN 3'h5

// ****************************************************************
// configuration fields
// ****************************************************************
`define MCD_CFG_EN 0
`define MCD_CFG_MEM 1
`define MCD_CFG_CIRC 2
`define MCD_CFG_SINC 3
`define MCD_CFG_DINC 4
`define MCD_CFG_SSZ 5
`define MCD_CFG_DSZ 7
`define MCD_CFG_PRIO 9
`define MCD_CFG_RSEL 11
`define MCD_CFG_SWSEL 17
`define MCD_CFG_BLKEN 18

// ****************************************************************
// ahb encodings
// ****************************************************************
`define MCD_HTRANS_IDLE 2'h0
`define MCD_HTRANS_NONSEQ 2'h2

`endif

// ---- rtl/mcd_pkg.sv ----
/*
  Types of the multi-channel mover: engine states and unit sizes.
  Assumes nothing of its surroundings.
*/
package mcd_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    MCD_IDLE = 3'h0,
    MCD_RADDR = 3'h1,
    MCD_RDATA = 3'h2,
    MCD_WADDR = 3'h3,
    MCD_WDATA = 3'h4
  } mcd_state_t;

  typedef enum logic [1:0] {
    MCD_SZ_BYTE = 2'h0,
    MCD_SZ_HALF = 2'h1,
    MCD_SZ_WORD = 2'h2
  } mcd_size_t;

endpackage

// ---- rtl/mcd_arb_if.sv ----
/*
  Interface between the mover core and its channel arbiter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`include "mcd_defines.svh"

interface mcd_arb_if;
  logic [`MCD_NCH-1:0] ready;
  logic [2*`MCD_NCH-1:0] prio;
  logic gntValid;
  logic [2:0] gntIdx;

  modport arb(input ready, input prio, output gntValid, output gntIdx);
  modport user(output ready, output prio, input gntValid, input gntIdx);
endinterface

// ---- rtl/mcd_arbiter.sv ----
/*
  Combinational channel arbiter: highest priority level wins, lowest
  channel number breaks a tie.
  Assumes the user samples the grant only while it is idle.
*/
`timescale 1ns/10ps
`include "mcd_defines.svh"

module mcd_arbiter (
  mcd_arb_if.arb bus
);

  // ****************************************************************
  // selection
  // ****************************************************************
  // later hits overwrite earlier ones: levels rise, channels fall
  function automatic logic [3:0] mcd_pick(input logic [7:0] rdy, input logic [15:0] pr);
    logic [3:0] res;
    res = 4'h0;
    for (int lvl = 0; lvl < 4; lvl++) begin
      for (int c = 7; c >= 0; c--) begin
        if (rdy[c] && pr[2*c+:2] == lvl[1:0]) begin
          res = {1'b1, c[2:0]};
        end
      end
    end
    return res;
  endfunction

  wire [3:0] pick = mcd_pick(bus.ready, bus.prio);

  // grant outputs
  assign bus.gntValid = pick[3];
  assign bus.gntIdx = pick[2:0];

endmodule

// ---- rtl/mcd_req_sync.sv ----
/*
  Three-stage synchroniser for peripheral request lines; a change is
  accepted once the second and third stage agree.
  Assumes request lines are levels from other clock domains.
*/
`timescale 1ns/10ps

module mcd_req_sync #(
  parameter int W = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] reqIn,
  output logic [W-1:0] reqOut
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // ****************************************************************
  // capture chain
  // ****************************************************************
  // stage1 feeds stage2 only, so metastability never reaches logic
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      reqOut <= '0;
    end else begin
      stage1 <= reqIn;
      stage2 <= stage1;
      stage3 <= stage2;
      reqOut <= (~(stage2 ^ stage3) & stage2) | ((stage2 ^ stage3) & reqOut);
    end
  end

endmodule

// ---- rtl/mcd_top.sv ----
/*
  Multi-channel mover: eight channels sharing one AHB-Lite master port,
  configured over a classic Wishbone slave.
  Assumes single-clock AHB slaves and an AHB-Lite fabric taking SINGLE
  transfers; request lines may come from any clock domain.
*/
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "mcd_defines.svh"

module mcd_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [11:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [`MCD_NREQ-1:0] dmaReq,
  output logic irq,
  output logic [3*`MCD_NCH-1:0] peripheralTaskTrigger
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [31:0] mcd_step(input logic [1:0] sz);
    return (sz == mcd_pkg::MCD_SZ_BYTE) ? 32'h1 : (sz == mcd_pkg::MCD_SZ_HALF) ? 32'h2 : 32'h4;
  endfunction

  function automatic logic [31:0] mcd_lane_get(input logic [31:0] d, input logic [1:0] off,
                                               input logic [1:0] sz);
    logic [31:0] s;
    s = d >> {off, 3'h0};
    return (sz == mcd_pkg::MCD_SZ_BYTE) ? {24'h0, s[7:0]} :
           (sz == mcd_pkg::MCD_SZ_HALF) ? {16'h0, s[15:0]} : s;
  endfunction

  function automatic logic [31:0] mcd_lane_put(input logic [31:0] d, input logic [1:0] sz);
    return (sz == mcd_pkg::MCD_SZ_BYTE) ? {4{d[7:0]}} :
           (sz == mcd_pkg::MCD_SZ_HALF) ? {2{d[15:0]}} : d;
  endfunction

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [`MCD_CFG_W-1:0] cfg [`MCD_NCH];
  logic [31:0] srcBase [`MCD_NCH];
  logic [31:0] dstBase [`MCD_NCH];
  logic [31:0] curSrc [`MCD_NCH];
  logic [31:0] curDst [`MCD_NCH];
  logic [`MCD_CNT_W-1:0] cnt [`MCD_NCH];
  logic [`MCD_CNT_W-1:0] remain [`MCD_NCH];
  logic [`MCD_CNT_W-1:0] credit [`MCD_NCH];
  logic [15:0] blk [`MCD_NCH];
  logic [23:0] status;
  logic [23:0] mask;
  logic [23:0] trigEn;
  logic [7:0] swPulse;
  logic [`MCD_NREQ-1:0] reqNow;
  logic [`MCD_NREQ-1:0] reqPrev;
  mcd_pkg::mcd_state_t state;
  logic [2:0] chSel;
  logic [31:0] unitData;

  mcd_arb_if arbBus ();

  // request lines cross into the bus clock here
  mcd_req_sync #(.W(`MCD_NREQ)) reqSync (
    .clk(clk),
    .reset(reset),
    .reqIn(dmaReq),
    .reqOut(reqNow)
  );

  mcd_arbiter arbiter (
    .bus(arbBus)
  );

  // ****************************************************************
  // wishbone decode
  // ****************************************************************
  // writes commit at the edge where the master samples ack
  wire wbReq = wbCyc & wbStb;
  wire wbWr = wbReq & wbWe & wbAck;
  wire chHit = wbAdr[11:8] == `MCD_CH_PAGE;
  wire globHit = wbAdr[11:8] == 4'h0;
  wire [2:0] wbCh = wbAdr[7:5];
  wire [2:0] wbIdx = wbAdr[4:2];
  wire [11:0] wbOff = {wbAdr[11:2], 2'h0};
  wire [31:0] wMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
  wire [7:0] enables;
  wire [31:0] chRd = (wbIdx == `MCD_CH_CFG) ? {13'h0, cfg[wbCh]} :
                     (wbIdx == `MCD_CH_SRC) ? srcBase[wbCh] :
                     (wbIdx == `MCD_CH_DST) ? dstBase[wbCh] :
                     (wbIdx == `MCD_CH_CNT) ? {15'h0, cnt[wbCh]} :
                     (wbIdx == `MCD_CH_BLK) ? {16'h0, blk[wbCh]} :
                     (wbIdx == `MCD_CH_REMAIN) ? {15'h0, remain[wbCh]} : 32'h0;
  wire [31:0] globRd = (wbOff == `MCD_REG_STATUS) ? {8'h0, status} :
                       (wbOff == `MCD_REG_MASK) ? {8'h0, mask} :
                       (wbOff == `MCD_REG_TRIGEN) ? {8'h0, trigEn} :
                       (wbOff == `MCD_REG_ACTIVE) ? {20'h0, state != mcd_pkg::MCD_IDLE, chSel, enables} :
                       32'h0;
  wire [31:0] rdMux = chHit ? chRd : (globHit ? globRd : 32'h0);
  wire [31:0] wrVal = (rdMux & ~wMask) | (wbDatW & wMask);
  wire globWr = wbWr & globHit;
  wire chWr = wbWr & chHit;
  wire [7:0] chOh = 8'h01 << wbCh;
  wire [7:0] cfgWr = (chWr && wbIdx == `MCD_CH_CFG) ? chOh : 8'h00;
  wire [23:0] stClr = (globWr && wbOff == `MCD_REG_STATUS) ? (wbDatW[23:0] & wMask[23:0]) : 24'h0;
  wire [`MCD_CNT_W-1:0] cntVal = wrVal[16] ? `MCD_CNT_MAX : wrVal[`MCD_CNT_W-1:0];

  // ack for every address, unmapped ones read zero and ignore writes
  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0;
    end else begin
      wbAck <= wbReq & ~wbAck;
      wbDatR <= rdMux;
    end
  end

  // ****************************************************************
  // engine decode
  // ****************************************************************
  wire unitDone = (state == mcd_pkg::MCD_WDATA) & hready & ~hresp;
  wire unitErr = ((state == mcd_pkg::MCD_RDATA) | (state == mcd_pkg::MCD_WDATA)) & hready & hresp;
  wire [`MCD_CNT_W-1:0] remNext = remain[chSel] - 17'h1;
  wire [`MCD_CNT_W-1:0] halfMark = cnt[chSel] - {1'b0, cnt[chSel][16:1]};
  wire lastUnit = remNext == 17'h0;
  wire [7:0] selOh = 8'h01 << chSel;
  wire [7:0] evTc = (unitDone && lastUnit) ? selOh : 8'h00;
  wire [7:0] evHt = (unitDone && remNext == halfMark) ? selOh : 8'h00;
  wire [7:0] evTe = unitErr ? selOh : 8'h00;
  wire [23:0] events = {evTe, evHt, evTc};
  wire [7:0] reqEdge;
  wire [7:0] take;

  // per-channel readiness, pacing and request selection
  for (genvar g = 0; g < `MCD_NCH; g++) begin : gChan
    wire [5:0] line = cfg[g][`MCD_CFG_RSEL+:6];
    // a request counts on its rising edge, software request by pulse
    assign reqEdge[g] = cfg[g][`MCD_CFG_SWSEL] ? swPulse[g] : (reqNow[line] & ~reqPrev[line]);
    assign take[g] = unitDone && chSel == g && !cfg[g][`MCD_CFG_MEM];
    // memory mode skips the credit check entirely
    assign arbBus.ready[g] = cfg[g][`MCD_CFG_EN] && remain[g] != 17'h0 &&
                             (cfg[g][`MCD_CFG_MEM] || credit[g] != 17'h0);
    assign arbBus.prio[2*g+:2] = cfg[g][`MCD_CFG_PRIO+:2];
    assign enables[g] = cfg[g][`MCD_CFG_EN];
  end

  // ****************************************************************
  // global registers and events
  // ****************************************************************
  // a flag raised in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= 24'h0;
      mask <= 24'h0;
      trigEn <= 24'h0;
      swPulse <= 8'h00;
      reqPrev <= '0;
    end else begin
      status <= (status & ~stClr) | events;
      if (globWr && wbOff == `MCD_REG_MASK) begin
        mask <= wrVal[23:0];
      end
      if (globWr && wbOff == `MCD_REG_TRIGEN) begin
        trigEn <= wrVal[23:0];
      end
      swPulse <= (globWr && wbOff == `MCD_REG_SWREQ) ? (wbDatW[7:0] & wMask[7:0]) : 8'h00;
      reqPrev <= reqNow;
    end
  end

  // interrupt level and trigger pulses, both registered
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
      peripheralTaskTrigger <= 24'h0;
    end else begin
      irq <= |(status & mask);
      peripheralTaskTrigger <= events & trigEn;
    end
  end

  // ****************************************************************
  // channel configuration
  // ****************************************************************
  // hardware drops enable on finish or error; a same-cycle write wins
  always_ff @(posedge clk) begin
    for (int c = 0; c < `MCD_NCH; c++) begin
      if (reset) begin
        cfg[c] <= '0;
        srcBase[c] <= 32'h0;
        dstBase[c] <= 32'h0;
        cnt[c] <= '0;
        blk[c] <= 16'h1;
      end else begin
        if (chSel == c[2:0] && (unitErr || (unitDone && lastUnit && !cfg[c][`MCD_CFG_CIRC]))) begin
          cfg[c][`MCD_CFG_EN] <= 1'b0;
        end
        if (cfgWr[c]) begin
          cfg[c] <= wrVal[`MCD_CFG_W-1:0];
        end
        if (chWr && wbCh == c[2:0] && wbIdx == `MCD_CH_SRC) begin
          srcBase[c] <= wrVal;
        end
        if (chWr && wbCh == c[2:0] && wbIdx == `MCD_CH_DST) begin
          dstBase[c] <= wrVal;
        end
        if (chWr && wbCh == c[2:0] && wbIdx == `MCD_CH_CNT) begin
          cnt[c] <= cntVal;
        end
        if (chWr && wbCh == c[2:0] && wbIdx == `MCD_CH_BLK) begin
          blk[c] <= wrVal[15:0];
        end
      end
    end
  end

  // ****************************************************************
  // channel working state
  // ****************************************************************
  // enabling a channel loads its working copy; cyclic mode reloads it
  always_ff @(posedge clk) begin
    for (int c = 0; c < `MCD_NCH; c++) begin
      if (reset) begin
        curSrc[c] <= 32'h0;
        curDst[c] <= 32'h0;
        remain[c] <= '0;
        credit[c] <= '0;
      end else if (cfgWr[c] && wrVal[`MCD_CFG_EN] && !cfg[c][`MCD_CFG_EN]) begin
        curSrc[c] <= srcBase[c];
        curDst[c] <= dstBase[c];
        remain[c] <= cnt[c];
        credit[c] <= '0;
      end else begin
        if (unitDone && chSel == c[2:0]) begin
          if (lastUnit && cfg[c][`MCD_CFG_CIRC]) begin
            remain[c] <= cnt[c];
            curSrc[c] <= srcBase[c];
            curDst[c] <= dstBase[c];
          end else begin
            remain[c] <= remNext;
            curSrc[c] <= curSrc[c] + (cfg[c][`MCD_CFG_SINC] ? mcd_step(cfg[c][`MCD_CFG_SSZ+:2]) : 32'h0);
            curDst[c] <= curDst[c] + (cfg[c][`MCD_CFG_DINC] ? mcd_step(cfg[c][`MCD_CFG_DSZ+:2]) : 32'h0);
          end
        end
        // one request grants one unit, or a whole block in block mode
        credit[c] <= credit[c] - {16'h0, take[c]} +
                     (reqEdge[c] ? (cfg[c][`MCD_CFG_BLKEN] ? {1'b0, blk[c]} : 17'h1) : 17'h0);
      end
    end
  end

  // ****************************************************************
  // ahb engine
  // ****************************************************************
  // re-arbitration after every unit is what lets a higher channel preempt
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= mcd_pkg::MCD_IDLE;
      chSel <= 3'h0;
      haddr <= 32'h0;
      htrans <= `MCD_HTRANS_IDLE;
      hwrite <= 1'b0;
      hsize <= 3'h0;
      hwdata <= 32'h0;
      unitData <= 32'h0;
    end else begin
      unique case (state)
        mcd_pkg::MCD_IDLE: begin
          if (arbBus.gntValid) begin
            chSel <= arbBus.gntIdx;
            haddr <= curSrc[arbBus.gntIdx];
            hsize <= 3'(mcd_step(cfg[arbBus.gntIdx][`MCD_CFG_SSZ+:2]) >> 1); // code 3 goes out as a word
            htrans <= `MCD_HTRANS_NONSEQ;
            hwrite <= 1'b0;
            state <= mcd_pkg::MCD_RADDR;
          end
        end
        mcd_pkg::MCD_RADDR: begin
          if (hready) begin
            htrans <= `MCD_HTRANS_IDLE;
            state <= mcd_pkg::MCD_RDATA;
          end
        end
        mcd_pkg::MCD_RDATA: begin
          if (hready && hresp) begin
            state <= mcd_pkg::MCD_IDLE;
          end else if (hready) begin
            unitData <= mcd_lane_get(hrdata, haddr[1:0], hsize[1:0]);
            haddr <= curDst[chSel];
            hsize <= 3'(mcd_step(cfg[chSel][`MCD_CFG_DSZ+:2]) >> 1); // never an illegal size
            htrans <= `MCD_HTRANS_NONSEQ;
            hwrite <= 1'b1;
            state <= mcd_pkg::MCD_WADDR;
          end
        end
        mcd_pkg::MCD_WADDR: begin
          if (hready) begin
            htrans <= `MCD_HTRANS_IDLE;
            hwdata <= mcd_lane_put(unitData, hsize[1:0]);
            state <= mcd_pkg::MCD_WDATA;
          end
        end
        mcd_pkg::MCD_WDATA: begin
          if (hready) begin
            hwrite <= 1'b0;
            state <= mcd_pkg::MCD_IDLE;
          end
        end
        default: begin
          state <= mcd_pkg::MCD_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- verif/mcd_sva.sv ----
/*
  Checker of the mover's bus handshakes and event outputs.
  Assumes it is bound onto mcd_top, one clock domain.
*/
`timescale 1ns/10ps

module mcd_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic wbAck,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hresp,
  input wire logic irq,
  input wire logic [23:0] peripheralTaskTrigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ********
  // unit steps
  // ********
  // a read address phase taken, then a clean read data phase
  sequence rdTaken;
    htrans == 2'h2 && !hwrite && hready;
  endsequence
  sequence rdDone;
    hready && !hresp;
  endsequence
  chk_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("request not acknowledged one cycle later");
  chk_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  chk_addr_hold: assert property (htrans == 2'h2 && !hready |=> htrans == 2'h2 && $stable(haddr))
    else $error("address phase changed while stalled");
  chk_rd_then_wr: assert property (rdTaken ##1 rdDone |=> htrans == 2'h2 && hwrite)
    else $error("read data not followed by the write address");
  chk_wr_idle: assert property (htrans == 2'h2 && hwrite && hready |=> htrans == 2'h0)
    else $error("no idle cycle after a write address");
  chk_size_legal: assert property (htrans == 2'h2 |-> hsize <= 3'h2)
    else $error("illegal transfer size");
  chk_trig_pulse: assert property (|peripheralTaskTrigger |=> !(|peripheralTaskTrigger))
    else $error("trigger longer than one cycle");
  chk_irq_clear: assert property ($fell(irq) |-> $past(wbAck && wbWe, 2))
    else $error("interrupt dropped without a register write");
endmodule

// ---- verif/mcd_ahb_mem.sv ----
/*
  AHB memory model with wait states and an error region.
  Assumes SINGLE transfers; addresses with bit 15 set answer with an error.
*/
`timescale 1ns/10ps

module mcd_ahb_mem (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic [1:0] waitCyc,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp
);
  logic [7:0] mem [0:4095];
  logic ph, wr, bad;
  logic [11:0] a;
  logic [2:0] sz;
  logic [1:0] w;
  logic [31:0] word;
  assign word = {mem[{a[11:2], 2'h3}], mem[{a[11:2], 2'h2}], mem[{a[11:2], 2'h1}], mem[{a[11:2], 2'h0}]};
  assign hready = !ph || w == 2'h0;
  assign hresp = ph && bad;
  // outside a read data phase the lines carry the inverse, never a stale match
  assign hrdata = (ph && !wr && hready) ? word : ~word;
  // only the lanes of the unit's size are written
  always @(posedge clk) begin
    if (reset) begin
      ph <= 1'b0;
      w <= 2'h0;
    end else if (hready) begin
      if (ph && wr && !bad)
        for (int k = 0; k < 4; k++)
          if ((k >> sz) == (int'(a[1:0]) >> sz))
            mem[{a[11:2], 2'(k)}] <= hwdata[8*k +: 8];
      ph <= htrans == 2'h2;
      wr <= hwrite;
      a <= haddr[11:0];
      sz <= hsize;
      bad <= haddr[15];
      w <= waitCyc;
    end else
      w <= w - 2'h1;
  end
endmodule

// ---- verif/mcd_top_tb.sv ----
/*
  Self-checking bench of the multi-channel mover.
  Assumes the design, the checker and the memory model are compiled first.
*/
`timescale 1ns/10ps
`include "mcd_defines.svh"

module mcd_top_tb;
  logic clk, reset, wbCyc, wbStb, wbWe, wbAck, hwrite, hready, hresp, irq, grab;
  logic [11:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, haddr, hwdata, hrdata, q, v, firstW;
  logic [1:0] htrans, waitCyc;
  logic [2:0] hsize;
  logic [63:0] dmaReq;
  logic [23:0] trig;
  int errors, num_checks, trigCnt, ch, r;

  mcd_top dut_u (.clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp),
    .dmaReq(dmaReq), .irq(irq), .peripheralTaskTrigger(trig));
  mcd_ahb_mem mem_u (.clk(clk), .reset(reset), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .waitCyc(waitCyc), .hrdata(hrdata), .hready(hready), .hresp(hresp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // count trigger pulses and catch the first write address of a race
  always @(posedge clk) begin
    trigCnt += $countones(trig);
    if (grab && htrans == 2'h2 && hwrite && hready) begin
      firstW <= haddr;
      grab <= 1'b0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    @(posedge clk);
    while (wbAck !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) errors++;
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  function automatic logic [11:0] ca(input int c, input int w);
    return 12'h100 + 12'(c * 32 + w * 4);
  endfunction

  function automatic logic [31:0] cf(input int m, input int ss, input int ds, input int pr, input int sw);
    return 32'(1 | m << 1 | 3 << 3 | ss << 5 | ds << 7 | pr << 9 | sw << 17);
  endfunction

  // enable goes last so that its rising edge loads the channel
  task automatic go(input int c, input logic [31:0] s, input logic [31:0] d, input logic [31:0] n,
    input logic [31:0] cfg);
    wr(ca(c, 0), 32'h0);
    wr(ca(c, 1), s);
    wr(ca(c, 2), d);
    wr(ca(c, 3), n);
    wr(ca(c, 0), cfg);
  endtask

  task automatic waitSt(input int b);
    int n;
    n = 0;
    do begin
      rd(`MCD_REG_STATUS);
      n++;
    end while (q[b] !== 1'b1 && n < 100);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a hang is cut short well past the expected length of the run
  initial begin
    #6000000;
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h0E5C));
    {errors, num_checks, trigCnt, grab, reset} = {32'h0, 32'h0, 32'h0, 1'b0, 1'b1};
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW, dmaReq, waitCyc} = {15'h0, 4'hF, 98'h0};
    for (int i = 0; i < 4096; i++) mem_u.mem[i] = 8'($urandom);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    // reset values, a hole in the map, the count ceiling
    rd(`MCD_REG_STATUS);
    chk(q, 32'h0);
    rd(ca(0, 4));
    chk(q, 32'h1);
    wr(12'h0F0, 32'hFFFFFFFF);
    rd(12'h0F0);
    chk(q, 32'h0);
    wr(`MCD_REG_MASK, 32'h00FFFFFF);
    wr(`MCD_REG_TRIGEN, 32'h00FFFFFF);
    wr(ca(7, 3), 32'h0001FFFF);
    rd(ca(7, 3));
    chk(q, 32'h00010000);
    // every pair of unit sizes, memory mode, aligned addresses, slow and quick memory
    for (int ss = 0; ss < 3; ss++)
      for (int ds = 0; ds < 3; ds++) begin
        ch = $urandom % 8;
        waitCyc <= 2'((ss + ds) % 3);
        for (int i = 0; i < 16; i++) mem_u.mem[12'h400 + i] = 8'h00;
        trigCnt = 0;
        go(ch, 32'h100, 32'h400, 32'h2, cf(1, ss, ds, 0, 0));
        waitSt(ch);
        chk(q, 32'h101 << ch);
        chk(irq, 1'b1);
        chk(trigCnt, 2);
        for (int u = 0; u < 2; u++)
          for (int k = 0; k < (1 << ds); k++) begin
            v = 32'h0;
            for (int j = 0; j < (1 << ss); j++) v[8*j +: 8] = mem_u.mem[12'h100 + u * (1 << ss) + j];
            chk(mem_u.mem[12'h400 + u * (1 << ds) + k], v[8*k +: 8]);
          end
        wr(`MCD_REG_STATUS, 32'h101 << ch);
        @(posedge clk);
        chk(irq, 1'b0);
      end
    // a paced channel waits for its own line, other lines are raised at random and held
    ch = $urandom % 8;
    r = $urandom % 64;
    go(ch, 32'h100, 32'h500, 32'h2, cf(0, 2, 2, 0, 0) | 32'(r) << 11);
    dmaReq <= {$urandom, $urandom} & ~(64'h1 << r);
    repeat (30) @(posedge clk);
    rd(ca(ch, 5));
    chk(q, 32'h2);
    dmaReq[r] <= 1'b1;
    repeat (8) @(posedge clk);
    dmaReq[r] <= 1'b0;
    repeat (20) @(posedge clk);
    rd(ca(ch, 5));
    chk(q, 32'h1);
    // one software request hands a block of three units over
    ch = (ch + 1) % 8;
    wr(ca(ch, 4), 32'h3);
    go(ch, 32'h100, 32'h600, 32'h6, cf(0, 2, 2, 0, 1) | 32'h40000);
    wr(`MCD_REG_SWREQ, 32'h1 << ch);
    repeat (40) @(posedge clk);
    rd(ca(ch, 5));
    chk(q, 32'h3);
    // cyclic channel reloads after two units and stays enabled
    ch = (ch + 1) % 8;
    go(ch, 32'h100, 32'h700, 32'h2, cf(0, 2, 2, 0, 1) | 32'h4);
    repeat (3) begin
      wr(`MCD_REG_SWREQ, 32'h1 << ch);
      repeat (20) @(posedge clk);
    end
    rd(ca(ch, 5));
    chk(q, 32'h1);
    rd(ca(ch, 0));
    chk(q[0], 1'b1);
    wr(ca(ch, 0), 32'h0);
    // two channels woken together: higher level first, a tie to the lower number
    for (int t = 0; t < 3; t++) begin
      go(2, 32'h100, 32'h800, 32'h1, cf(0, 2, 2, t + 1, 1));
      go(5, 32'h100, 32'h900, 32'h1, cf(0, 2, 2, (t == 2) ? 0 : 2, 1));
      grab = 1'b1;
      wr(`MCD_REG_SWREQ, 32'h24);
      repeat (30) @(posedge clk);
      chk(firstW, (t == 0) ? 32'h900 : 32'h800);
    end
    // a bus error raises the error flag and stops the channel
    wr(`MCD_REG_STATUS, 32'h00FFFFFF);
    go(3, 32'h8000, 32'h400, 32'h1, cf(1, 2, 2, 0, 0));
    waitSt(19);
    chk(q[19], 1'b1);
    rd(ca(3, 0));
    chk(q[0], 1'b0);
    // a count of zero never runs and raises nothing
    wr(`MCD_REG_STATUS, 32'h00FFFFFF);
    go(4, 32'h100, 32'hA00, 32'h0, cf(1, 2, 2, 0, 0));
    repeat (30) @(posedge clk);
    rd(`MCD_REG_STATUS);
    chk(q, 32'h0);
    complete_run();
  end
endmodule

bind mcd_top mcd_sva chk_u (.clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAck(wbAck), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hresp(hresp), .irq(irq), .peripheralTaskTrigger(peripheralTaskTrigger));
